// ===== core/adc_cfg_pkg.sv
// Purpose: Shared constants for the serial configuration register bank.
// Assumes: Core clock of 250 MHz; registers are 11 bits wide behind a 5-bit address.
// Notes:   Masks mark the bits that carry a function; all other bits hold zero.
package adc_cfg_pkg;

  // Frame layout: the address is shifted first, then the data.
  localparam int FRAME_BITS = 16;
  localparam int ADDR_BITS  = 5;
  localparam int DATA_BITS  = 11;
  localparam int NUM_REGS   = 8;
  localparam int SLOT_BITS  = 3;

  // Register addresses.
  localparam logic [4:0] ADDR_RESET_POWER  = 5'h00;
  localparam logic [4:0] ADDR_CLKIN_GAIN   = 5'h04;
  localparam logic [4:0] ADDR_FORMAT_TEST  = 5'h0A;
  localparam logic [4:0] ADDR_USER_LOW     = 5'h0B;
  localparam logic [4:0] ADDR_GAIN_USER_TOP = 5'h0C;
  localparam logic [4:0] ADDR_SERIAL_MODE  = 5'h0D;
  localparam logic [4:0] ADDR_CLK_DRIVE    = 5'h10;
  localparam logic [4:0] ADDR_DATA_DRIVE   = 5'h11;

  // Storage slots, one per implemented register.
  localparam logic [2:0] SLOT_RESET_POWER   = 3'h0;
  localparam logic [2:0] SLOT_CLKIN_GAIN    = 3'h1;
  localparam logic [2:0] SLOT_FORMAT_TEST   = 3'h2;
  localparam logic [2:0] SLOT_USER_LOW      = 3'h3;
  localparam logic [2:0] SLOT_GAIN_USER_TOP = 3'h4;
  localparam logic [2:0] SLOT_SERIAL_MODE   = 3'h5;
  localparam logic [2:0] SLOT_CLK_DRIVE     = 3'h6;
  localparam logic [2:0] SLOT_DATA_DRIVE    = 3'h7;

  // Functional bit masks per register.
  localparam logic [10:0] MASK_RESET_POWER   = 11'h42D;
  localparam logic [10:0] MASK_CLKIN_GAIN    = 11'h07C;
  localparam logic [10:0] MASK_FORMAT_TEST   = 11'h2E0;
  localparam logic [10:0] MASK_USER_LOW      = 11'h7FF;
  localparam logic [10:0] MASK_GAIN_USER_TOP = 11'h701;
  localparam logic [10:0] MASK_SERIAL_MODE   = 11'h4F7;
  localparam logic [10:0] MASK_CLK_DRIVE     = 11'h7FF;
  localparam logic [10:0] MASK_DATA_DRIVE    = 11'h41F;
  localparam logic [10:0] MASK_STRAP_MODES   = 11'h0F7;

  // Reset value of every register.
  localparam logic [10:0] REG_RESET_VALUE = 11'h000;

  // Field positions.
  localparam int SOFT_RESET_BIT  = 10;
  localparam int PIN_OVERRIDE_BIT = 10;
  localparam int GLOBAL_PDN_BIT  = 0;

  // Timing.
  localparam int  CLK_PERIOD_NS    = 4;
  localparam int  APPLY_DELAY_NS   = 100;
  localparam int  APPLY_CYCLES     = (APPLY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam real OUTPUT_STABLE_MS = 6.5;
  localparam int  STABLE_CYCLES    = int'(OUTPUT_STABLE_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam logic [4:0] APPLY_LOAD = 5'(APPLY_CYCLES - 1);

endpackage

// ===== core/adc_cfg_regs.sv
// Purpose: Serial-written configuration register bank of a dual-channel converter.
// Assumes: Serial clock, strobe, data, reset and strap pins are asynchronous to clk_in and
//          the serial clock is far slower than clk_in (80 ns period in the bench).
// Notes:   Strap levels use the bit layout of the serializer mode register.
// Contract
// - New register value takes effect no sooner than 100 ns after 16th falling edge.
// - Output data counts as stable 6.5 ms after power up.
// - All fields of one register are updated together by one frame.
// - Address 00 holds soft reset, reference, channel B, channel A, global power down.
// - Address 0A holds number format at D9 and test select at D7 to D5.
// - User word low eleven bits at 0B, top bit at 0C bit D0.
// - Address 0C holds step gain in D10 to D8, zeros in D7 to D1.
// - Address 0D holds pin override and the serializer mode bits.
// - Address 10 holds clock termination, drive level and drive boost.
// - Address 11 holds word-wise control on top, data termination in low bits.
// - Frame is 5 address bits first, then 11 data bits.
// - Data sampled on falling serial clock while strobe low; commit every 16th.
// - Strapped modes follow the register only when pin override is high.
// - Soft reset bit returns all registers to defaults and reads back zero.
`timescale 1ns/10ps
module adc_cfg_regs #(
  parameter int unsigned STABLE_CYCLES_P = adc_cfg_pkg::STABLE_CYCLES
) (
  // Clock and reset.
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  // Serial write port pins.
  input  wire logic        serial_write_strobe_n_in,
  input  wire logic        serial_clock_in,
  input  wire logic        serial_write_line_in,
  input  wire logic        hw_reset_in,
  // Configuration pins.
  input  wire logic        power_down_pin_in,
  input  wire logic [10:0] strap_mode_in,
  // Register contents.
  output logic      [10:0] reset_and_power_control_out,
  output logic      [10:0] clock_input_buffer_gain_out,
  output logic      [10:0] output_format_and_test_select_out,
  output logic      [10:0] user_word_low_bits_out,
  output logic      [10:0] step_gain_and_user_word_top_out,
  output logic      [10:0] serializer_mode_control_out,
  output logic      [10:0] clock_output_drive_control_out,
  output logic      [10:0] data_output_drive_control_out,
  // Effective controls and status.
  output logic      [10:0] serializer_mode_eff_out,
  output logic             global_power_down_out,
  output logic             write_pending_out,
  output logic             output_stable_out
);
  import adc_cfg_pkg::*;

  // Maps an address to {implemented, slot}.
  function automatic logic [3:0] slot_of(input logic [4:0] addr);
    logic [3:0] res;
    res = 4'h0;
    unique case (addr)
      ADDR_RESET_POWER:   res = {1'b1, SLOT_RESET_POWER};
      ADDR_CLKIN_GAIN:    res = {1'b1, SLOT_CLKIN_GAIN};
      ADDR_FORMAT_TEST:   res = {1'b1, SLOT_FORMAT_TEST};
      ADDR_USER_LOW:      res = {1'b1, SLOT_USER_LOW};
      ADDR_GAIN_USER_TOP: res = {1'b1, SLOT_GAIN_USER_TOP};
      ADDR_SERIAL_MODE:   res = {1'b1, SLOT_SERIAL_MODE};
      ADDR_CLK_DRIVE:     res = {1'b1, SLOT_CLK_DRIVE};
      ADDR_DATA_DRIVE:    res = {1'b1, SLOT_DATA_DRIVE};
      default:            res = 4'h0;
    endcase
    return res;
  endfunction

  // Functional bit mask of a slot.
  function automatic logic [10:0] mask_of(input logic [2:0] slot);
    logic [10:0] m;
    m = 11'h000;
    unique case (slot)
      SLOT_RESET_POWER:   m = MASK_RESET_POWER;
      SLOT_CLKIN_GAIN:    m = MASK_CLKIN_GAIN;
      SLOT_FORMAT_TEST:   m = MASK_FORMAT_TEST;
      SLOT_USER_LOW:      m = MASK_USER_LOW;
      SLOT_GAIN_USER_TOP: m = MASK_GAIN_USER_TOP;
      SLOT_SERIAL_MODE:   m = MASK_SERIAL_MODE;
      SLOT_CLK_DRIVE:     m = MASK_CLK_DRIVE;
      SLOT_DATA_DRIVE:    m = MASK_DATA_DRIVE;
    endcase
    return m;
  endfunction

  // Pin synchronisers: {strobe_n, sclk, serial_write_line, hw reset, power down} plus straps.
  logic [4:0]  pin_s1_ff, pin_s2_ff, nxt_pin_s1, nxt_pin_s2;
  logic [10:0] strap_s1_ff, strap_s2_ff, nxt_strap_s1, nxt_strap_s2;
  logic        sclk_prev_ff, nxt_sclk_prev;
  logic        strobe_n_s, sclk_s, serial_write_line_s, hw_rst_s, pdn_pin_s, sclk_fall;

  always_comb begin
    nxt_pin_s1    = {serial_write_strobe_n_in, serial_clock_in, serial_write_line_in,
                     hw_reset_in, power_down_pin_in};
    nxt_pin_s2    = pin_s1_ff;
    nxt_strap_s1  = strap_mode_in;
    nxt_strap_s2  = strap_s1_ff;
    nxt_sclk_prev = sclk_s;
  end

  always_ff @(posedge clk_in) begin
    pin_s1_ff    <= nxt_pin_s1;
    pin_s2_ff    <= nxt_pin_s2;
    strap_s1_ff  <= nxt_strap_s1;
    strap_s2_ff  <= nxt_strap_s2;
    sclk_prev_ff <= nxt_sclk_prev;
  end

  assign {strobe_n_s, sclk_s, serial_write_line_s, hw_rst_s, pdn_pin_s} = pin_s2_ff;
  assign sclk_fall = sclk_prev_ff & ~sclk_s;

  // Frame shifter and delayed apply. Excess bits short of a full frame are dropped
  // when the strobe rises, because the bit counter restarts.
  logic [15:0] shift_ff, nxt_shift;
  logic [3:0]  bit_cnt_ff, nxt_bit_cnt;
  logic        pend_ff, nxt_pend;
  logic [15:0] pend_frame_ff, nxt_pend_frame;
  logic [4:0]  apply_cnt_ff, nxt_apply_cnt;
  logic        commit, apply_now, any_reset;

  assign any_reset = ~resetn_in | hw_rst_s;
  assign commit    = ~strobe_n_s & sclk_fall & (bit_cnt_ff == 4'hF);
  assign apply_now = pend_ff & (apply_cnt_ff == 5'h00);

  always_comb begin
    nxt_shift      = shift_ff;
    nxt_bit_cnt    = bit_cnt_ff;
    nxt_pend       = pend_ff;
    nxt_pend_frame = pend_frame_ff;
    nxt_apply_cnt  = apply_cnt_ff;
    if (strobe_n_s) begin
      nxt_bit_cnt = 4'h0;
    end else if (sclk_fall) begin
      nxt_shift   = {shift_ff[14:0], serial_write_line_s};
      nxt_bit_cnt = bit_cnt_ff + 4'h1;
    end
    // A frame holds its write back for the settle time before anything sees it.
    if (commit) begin
      nxt_pend       = 1'b1;
      nxt_pend_frame = {shift_ff[14:0], serial_write_line_s};
      nxt_apply_cnt  = APPLY_LOAD;
    end else if (apply_now) begin
      nxt_pend = 1'b0;
    end else if (pend_ff) begin
      nxt_apply_cnt = apply_cnt_ff - 5'h01;
    end
    if (any_reset) begin
      nxt_bit_cnt = 4'h0;
      nxt_pend    = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    shift_ff      <= nxt_shift;
    bit_cnt_ff    <= nxt_bit_cnt;
    pend_ff       <= nxt_pend;
    pend_frame_ff <= nxt_pend_frame;
    apply_cnt_ff  <= nxt_apply_cnt;
  end

  // Register file and effective controls.
  logic [NUM_REGS-1:0][10:0] regs_ff, nxt_regs;
  logic [10:0] eff_mode_ff, nxt_eff_mode;
  logic        gpdn_ff, nxt_gpdn;
  logic [4:0]  pend_addr;
  logic [10:0] pend_data;
  logic [3:0]  pend_slot;

  assign pend_addr = pend_frame_ff[15:11];
  assign pend_data = pend_frame_ff[10:0];
  assign pend_slot = slot_of(pend_addr);

  always_comb begin
    nxt_regs = regs_ff;
    if (apply_now && pend_slot[3]) begin
      if (pend_slot[2:0] == SLOT_RESET_POWER && pend_data[SOFT_RESET_BIT]) begin
        nxt_regs = {NUM_REGS{REG_RESET_VALUE}};
      end else begin
        // Whole word at once; non-functional bits are forced to zero.
        nxt_regs[pend_slot[2:0]] = pend_data & mask_of(pend_slot[2:0]);
      end
    end
    if (any_reset) begin
      nxt_regs = {NUM_REGS{REG_RESET_VALUE}};
    end
    // Straps rule the modes unless the override bit hands them to the register.
    nxt_eff_mode = regs_ff[SLOT_SERIAL_MODE][PIN_OVERRIDE_BIT]
                   ? (regs_ff[SLOT_SERIAL_MODE] & MASK_STRAP_MODES)
                   : (strap_s2_ff & MASK_STRAP_MODES);
    nxt_gpdn = pdn_pin_s | regs_ff[SLOT_RESET_POWER][GLOBAL_PDN_BIT];
  end

  always_ff @(posedge clk_in) begin
    regs_ff     <= nxt_regs;
    eff_mode_ff <= nxt_eff_mode;
    gpdn_ff     <= nxt_gpdn;
  end

  // Power-up settle counter; only the core reset restarts it.
  logic [31:0] stable_cnt_ff, nxt_stable_cnt;
  logic        stable_ff, nxt_stable;

  always_comb begin
    nxt_stable_cnt = stable_cnt_ff;
    nxt_stable     = stable_ff;
    if (stable_cnt_ff != 32'(STABLE_CYCLES_P)) begin
      nxt_stable_cnt = stable_cnt_ff + 32'h1;
    end else begin
      nxt_stable = 1'b1;
    end
    if (!resetn_in) begin
      nxt_stable_cnt = 32'h0;
      nxt_stable     = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    stable_cnt_ff <= nxt_stable_cnt;
    stable_ff     <= nxt_stable;
  end

  // Output map.
  assign reset_and_power_control_out       = regs_ff[SLOT_RESET_POWER];
  assign clock_input_buffer_gain_out       = regs_ff[SLOT_CLKIN_GAIN];
  assign output_format_and_test_select_out = regs_ff[SLOT_FORMAT_TEST];
  assign user_word_low_bits_out            = regs_ff[SLOT_USER_LOW];
  assign step_gain_and_user_word_top_out   = regs_ff[SLOT_GAIN_USER_TOP];
  assign serializer_mode_control_out       = regs_ff[SLOT_SERIAL_MODE];
  assign clock_output_drive_control_out    = regs_ff[SLOT_CLK_DRIVE];
  assign data_output_drive_control_out     = regs_ff[SLOT_DATA_DRIVE];
  assign serializer_mode_eff_out           = eff_mode_ff;
  assign global_power_down_out             = gpdn_ff;
  assign write_pending_out                 = pend_ff;
  assign output_stable_out                 = stable_ff;

  // Checks.
  logic regs_clean;
  always_comb begin
    regs_clean = 1'b1;
    for (int i = 0; i < NUM_REGS; i++) begin
      if ((regs_ff[i] & ~mask_of(3'(i))) != 11'h000) regs_clean = 1'b0;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  chk_apply_delay_exact: assert property (commit && !hw_rst_s |-> ##25 apply_now)
    else $error("write applied at wrong time after frame end");
  // A commit must hold the whole frame, last bit included, behind the pending flag.
  chk_frame_edge_count: assert property (commit && !hw_rst_s |=> pend_ff
    && pend_frame_ff == $past({shift_ff[14:0], serial_write_line_s}))
    else $error("frame not held for apply after the sixteenth falling edge");
  chk_unmapped_ignored: assert property
    (apply_now && !pend_slot[3] && !hw_rst_s |=> $stable(regs_ff))
    else $error("unmapped write changed a register");
  chk_idle_regs_hold: assert property (!apply_now && !hw_rst_s |=> $stable(regs_ff))
    else $error("register changed without an applied write");
  chk_field_all_once: assert property (apply_now && pend_slot[3] && !hw_rst_s
    && !(pend_slot[2:0] == SLOT_RESET_POWER && pend_data[SOFT_RESET_BIT])
    |=> regs_ff[$past(pend_slot[2:0])] == ($past(pend_data) & mask_of($past(pend_slot[2:0]))))
    else $error("register not updated as a whole word");
  chk_reserved_zero: assert property (regs_clean)
    else $error("non-functional register bit is set");
  chk_soft_reset_all: assert property (apply_now && pend_slot[3]
    && pend_slot[2:0] == SLOT_RESET_POWER && pend_data[SOFT_RESET_BIT]
    |=> regs_ff == {NUM_REGS{REG_RESET_VALUE}})
    else $error("soft reset did not restore defaults");
  chk_override_select: assert property (##1 eff_mode_ff == ($past(regs_ff[SLOT_SERIAL_MODE][10])
    ? ($past(regs_ff[SLOT_SERIAL_MODE]) & MASK_STRAP_MODES)
    : ($past(strap_s2_ff) & MASK_STRAP_MODES)))
    else $error("mode source does not follow override bit");
  chk_global_pdn_or: assert property (##1 gpdn_ff == ($past(pdn_pin_s)
    | $past(regs_ff[SLOT_RESET_POWER][GLOBAL_PDN_BIT])))
    else $error("global power down wrong");
  chk_stable_count: assert property (stable_ff |-> stable_cnt_ff == 32'(STABLE_CYCLES_P))
    else $error("output stable raised before settle count");

endmodule // adc_cfg_regs

// ===== verification/adc_cfg_regs_tb.sv
// Purpose: Self-checking bench for the serial configuration register bank.
// Assumes: The host model owns the serial pins; the bench owns straps and power pin.
// Notes:   Each commit leaves a note of the whole register image; a monitor checks it.
`timescale 1ns/10ps
module adc_cfg_regs_tb;
  import adc_cfg_pkg::*;
  localparam int STABLE_P = 50;
  localparam logic [4:0] ADDRS [8] = '{ADDR_RESET_POWER, ADDR_CLKIN_GAIN, ADDR_FORMAT_TEST,
    ADDR_USER_LOW, ADDR_GAIN_USER_TOP, ADDR_SERIAL_MODE, ADDR_CLK_DRIVE, ADDR_DATA_DRIVE};
  localparam logic [10:0] MASKS [8] = '{MASK_RESET_POWER, MASK_CLKIN_GAIN, MASK_FORMAT_TEST,
    MASK_USER_LOW, MASK_GAIN_USER_TOP, MASK_SERIAL_MODE, MASK_CLK_DRIVE, MASK_DATA_DRIVE};
  logic        clk_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic        strobe_n, sclk, serial_write_line, hw_reset;
  logic        pdn_pin = 1'b0;
  logic [10:0] strap = 11'h000;
  logic [10:0] reg_pwr, reg_clkin, reg_fmt, reg_ulow;
  logic [10:0] reg_gtop, reg_smode, reg_cdrv, reg_ddrv;
  logic [10:0] model [8] = '{default: 11'h000};
  logic [10:0] eff;
  logic        gpdn, pending, stable;
  logic [87:0] notes [$];
  realtime     falls [$];
  int          failures = 0;
  int          samples_checked = 0;
  int          nfall = 0;
  logic        prev_pend = 1'b0;
  wire  [87:0] image = {reg_pwr, reg_clkin, reg_fmt, reg_ulow,
                        reg_gtop, reg_smode, reg_cdrv, reg_ddrv};

  // Clock of 250 MHz.
  always #2 clk_in = ~clk_in;

  cfg_host_model host (.clk_in(clk_in), .strobe_n_out(strobe_n), .sclk_out(sclk),
    .serial_write_line_out(serial_write_line), .hw_reset_out(hw_reset));

  adc_cfg_regs #(.STABLE_CYCLES_P(STABLE_P)) DUT (
    .clk_in(clk_in), .resetn_in(resetn_in), .serial_write_strobe_n_in(strobe_n),
    .serial_clock_in(sclk), .serial_write_line_in(serial_write_line), .hw_reset_in(hw_reset),
    .power_down_pin_in(pdn_pin), .strap_mode_in(strap),
    .reset_and_power_control_out(reg_pwr), .clock_input_buffer_gain_out(reg_clkin),
    .output_format_and_test_select_out(reg_fmt), .user_word_low_bits_out(reg_ulow),
    .step_gain_and_user_word_top_out(reg_gtop), .serializer_mode_control_out(reg_smode),
    .clock_output_drive_control_out(reg_cdrv), .data_output_drive_control_out(reg_ddrv),
    .serializer_mode_eff_out(eff), .global_power_down_out(gpdn),
    .write_pending_out(pending), .output_stable_out(stable));

  // Compares one result; values are widened so one task serves every kind.
  task automatic check_val(input logic [87:0] got, input logic [87:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Prints the counts and the verdict, then stops the run.
  task automatic end_sim();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Updates the expected image, notes it, then shifts the word out.
  task automatic post(input logic [4:0] a, input logic [10:0] d);
    logic [87:0] img;
    if (a == ADDR_RESET_POWER && d[SOFT_RESET_BIT]) begin
      foreach (model[i]) model[i] = REG_RESET_VALUE;
    end
    for (int i = 0; i < 8; i++) begin
      if (ADDRS[i] == a && !(i == 0 && d[SOFT_RESET_BIT])) model[i] = d & MASKS[i];
    end
    for (int i = 0; i < 8; i++) img[87 - 11 * i -: 11] = model[i];
    notes.push_back(img);
    host.word({a, d});
  endtask

  // Bounded wait until every noted write has been applied.
  task automatic drain();
    int k;
    for (k = 0; k < 3000 && (notes.size() > 0 || pending !== 1'b0); k++) @(posedge clk_in);
    if (k == 3000) begin
      failures++;
      $display("[FAIL] %0t wait limit reached", $time);
      end_sim();
    end
    host.step(2);
  endtask

  // One word in its own strobe.
  task automatic wr(input logic [4:0] a, input logic [10:0] d);
    host.open_frame();
    post(a, d);
    host.close_frame();
    drain();
  endtask

  // Times every sixteenth falling edge inside a strobe; a strobe rise restarts the count.
  always @(negedge sclk) begin
    if (!strobe_n) begin
      nfall++;
      if (nfall % 16 == 0) falls.push_back($realtime);
    end
  end
  always @(posedge strobe_n) nfall = 0;

  // An apply shows as the fall of the pending flag; the oldest note must match it.
  always @(posedge clk_in) begin
    #1;
    if (prev_pend === 1'b1 && pending === 1'b0) begin
      if (notes.size() == 0) check_val(image, '1, "apply without a commit");
      else check_val(image, notes.pop_front(), "register image");
      check_val(88'(($realtime - falls.pop_front()) >= 100.0), 88'd1, "apply delay");
    end
    prev_pend = pending;
  end

  initial begin
    logic [10:0] d;
    void'($urandom(36));
    repeat (3) @(posedge clk_in);
    #1 resetn_in = 1'b1;
    check_val(image, 88'h0, "reset image");
    host.step(40);
    check_val(88'(stable), 88'h0, "stable early");
    host.step(20);
    check_val(88'(stable), 88'h1, "stable late");
    host.hw_pulse(10);
    $display("test reset done");
    // Every register back to back in one strobe, then five excess bits.
    host.open_frame();
    for (int i = 0; i < 8; i++) post(ADDRS[i], 11'($urandom) & MASKS[i] & 11'h3FF);
    for (int i = 0; i < 5; i++) host.shift(1'b1);
    host.close_frame();
    drain();
    $display("test writes done");
    wr(5'h01, 11'h7FF);
    wr(5'h1F, 11'h555);
    $display("test unmapped done");
    for (int ov = 0; ov < 2; ov++) begin
      strap = 11'($urandom);
      d = {ov[0], 10'($urandom)} & MASK_SERIAL_MODE;
      wr(ADDR_SERIAL_MODE, d);
      check_val(88'(eff), 88'((ov ? d : strap) & MASK_STRAP_MODES), "modes");
    end
    $display("test override done");
    for (int k = 0; k < 4; k++) begin
      pdn_pin = k[1];
      wr(ADDR_RESET_POWER, 11'(k[0]) | 11'h02C);
      host.step(4);
      check_val(88'(gpdn), 88'(k[1] | k[0]), "power down");
    end
    $display("test power down done");
    wr(ADDR_USER_LOW, 11'h7FF);
    wr(ADDR_RESET_POWER, 11'h42D);
    $display("test soft reset done");
    wr(ADDR_GAIN_USER_TOP, 11'h601);
    host.hw_pulse(1);
    host.step(4);
    foreach (model[i]) model[i] = REG_RESET_VALUE;
    check_val(image, 88'h0, "hardware reset image");
    $display("test hardware reset done");
    end_sim();
  end
endmodule // adc_cfg_regs_tb

// ===== verification/cfg_host_model.sv
// Purpose: Host model that writes configuration frames over the serial port.
// Assumes: Every step lands 1 ns after a rising edge of clk_in.
// Notes:   The serial clock idles low and moves only inside frames.
`timescale 1ns/10ps
module cfg_host_model (
  // Clock.
  input  wire logic clk_in,
  // Serial port pins.
  output logic      strobe_n_out,
  output logic      sclk_out,
  output logic      serial_write_line_out,
  output logic      hw_reset_out
);
  // Aligning steps to the clock keeps every pin change off the sampling edge.
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // One bit of 80 ns: 48 ns setup and 32 ns hold around the falling edge.
  task automatic shift(input logic v);
    serial_write_line_out = v;
    step(2);
    sclk_out = 1'b1;
    step(10);
    sclk_out = 1'b0;
    step(8);
  endtask
  // Address first, then data, most significant bit first.
  task automatic word(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) shift(w[i]);
  endtask
  // The strobe leads the first clock edge by 40 ns.
  task automatic open_frame();
    strobe_n_out = 1'b0;
    step(8);
  endtask
  // A released data line shows the inverse of its last bit, never a held value.
  task automatic close_frame();
    step(8);
    strobe_n_out = 1'b1;
    serial_write_line_out = ~serial_write_line_out;
  endtask
  // The supply settle time is shortened; the pulse is 12 ns, then 28 ns of quiet.
  task automatic hw_pulse(input int settle);
    step(settle);
    hw_reset_out = 1'b1;
    step(3);
    hw_reset_out = 1'b0;
    step(7);
  endtask
  // Idle levels at time zero.
  initial begin
    strobe_n_out = 1'b1;
    sclk_out = 1'b0;
    serial_write_line_out = 1'b0;
    hw_reset_out = 1'b0;
  end
endmodule // cfg_host_model
